//--- hw/wrbc_ctrl.sv
// receiver digital control: status, rectifier mode, limit, temperature, backscatter
`timescale 1ns/1ns
// How it works
// R1: power good pulls low while supply enabled
// R2: supply stays off until rectifier converged
// R3: one encoded bit per 0.5 ms
// R4: one bit two transitions, zero one
// R5: 11-bit frame, data least significant first
// R6: start zero, odd parity, stop one
// R7: both modulation switches follow encoded stream
// R8: adaptive limit 400 mA or current plus 50
// R9: rectifier off, then half-synchronous past lockout
// R10: full above 120 mA, half below 100
// R11: 24 ms bias window, 10 ms deglitch
// R12: window end releases temperature bias output
// R13: monitor 35/235 ms, flag host control above
// R14: hot and cold comparators give fault flags
// R15: die overheat disables supply, sends internal fault
// R16: control error packet every 250 ms
// R17: second enable alone disables adaptive limit
// R18: idle link leaves both switches open
module wrbc_ctrl
  import wrbc_pkg::*;
#(
  parameter int HALF_CYC     = HALF_BIT_CYC,
  parameter int BIAS_CYC     = BIAS_WIN_CYC,
  parameter int DGL_CYC      = DEGLITCH_CYC,
  parameter int MON_P_CYC    = MON_PRIO_CYC,
  parameter int MON_S_CYC    = MON_STD_CYC,
  parameter int CE_INT_CYC   = CE_INTERVAL_CYC
)(
  input  wire logic             clk,
  input  wire logic             nrst,
  input  wire logic             ce,
  input  wire logic             rect_converged,
  input  wire logic             rect_above_uvlo,
  input  wire logic             hot_threshold,
  input  wire logic             cold_threshold,
  input  wire logic             host_sense_above,
  input  wire logic             die_shutdown_temp,
  input  wire logic             enable_select_a,
  input  wire logic             enable_select_b,
  input  wire logic [CUR_W-1:0] load_current_ma,
  input  wire logic [7:0]       ctrl_err_value,
  input  wire logic             priority_period,
  output logic                  power_good_n_o,
  output logic                  power_good_n_oe,
  output logic                  supply_enable,
  output logic                  rect_half_sync,
  output logic                  rect_full_sync,
  output logic                  comm_limit_en,
  output logic [CUR_W:0]        comm_limit_ma,
  output logic                  temp_bias_window,
  output logic                  temp_bias_output_oe,
  output logic                  hot_fault,
  output logic                  cold_fault,
  output logic                  host_ctrl,
  output logic                  modulation_switch_a,
  output logic                  modulation_switch_b
);
  wrbc_tx_if txi ();

  // the eight pins in pin_raw cross in through two flops; only the second stage is read
  logic [PIN_N-1:0] s1_ff;
  logic [PIN_N-1:0] s2_ff;
  logic [PIN_N-1:0] pin_raw;
  assign pin_raw = {enable_select_b, enable_select_a, die_shutdown_temp, host_sense_above,
                    cold_threshold, hot_threshold, rect_above_uvlo, rect_converged};

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      s1_ff <= '0;
      s2_ff <= '0;
    end
    else if (ce)
    begin
      s1_ff <= pin_raw;
      s2_ff <= s1_ff;
    end
  end

  function automatic logic cnt_done(input logic [31:0] c, input int lim);
    cnt_done = (c >= 32'(lim - 1));
  endfunction

  // supply, status and rectifier
  logic          conv_ff,  nxt_conv;
  logic          sup_ff,   nxt_sup;
  wrbc_rect_type rm_ff,    nxt_rm;
  logic          cle_ff,   nxt_cle;
  logic [CUR_W:0] clm_ff,  nxt_clm;
  logic          hotf_ff,  coldf_ff;

  always_comb
  begin
    nxt_conv = conv_ff | s2_ff[P_CONV]; // R2
    nxt_sup  = conv_ff & ~s2_ff[P_DIE] & ~hotf_ff & ~coldf_ff
               & ~(s2_ff[P_ENA] & s2_ff[P_ENB]); // R2 R15
    nxt_rm   = rm_ff;
    case (rm_ff)
      RM_OFF:
        if (s2_ff[P_UVLO])
          nxt_rm = RM_HALF; // R9
      RM_HALF:
        if (!s2_ff[P_UVLO])
          nxt_rm = RM_OFF;
        else if (load_current_ma > FULL_ON_MA)
          nxt_rm = RM_FULL; // R10
      RM_FULL:
        if (!s2_ff[P_UVLO])
          nxt_rm = RM_OFF;
        else if (load_current_ma < FULL_OFF_MA)
          nxt_rm = RM_HALF; // R10
      default:
        nxt_rm = RM_OFF;
    endcase
    nxt_cle = ~(s2_ff[P_ENB] & ~s2_ff[P_ENA]); // R17
    if (load_current_ma < CL_KNEE_MA)
      nxt_clm = CL_FIXED_MA; // R8
    else
      nxt_clm = {1'b0, load_current_ma} + CL_MARGIN_MA; // R8
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      conv_ff <= 1'b0;
      sup_ff  <= 1'b0;
      rm_ff   <= RM_OFF;
      cle_ff  <= 1'b1;
      clm_ff  <= CL_FIXED_MA;
    end
    else if (ce)
    begin
      conv_ff <= nxt_conv;
      sup_ff  <= nxt_sup;
      rm_ff   <= nxt_rm;
      cle_ff  <= nxt_cle;
      clm_ff  <= nxt_clm;
    end
  end

  // temperature bias cycle
  wrbc_ts_type ts_ff,    nxt_ts;
  logic [31:0] tcnt_ff,  nxt_tcnt;
  logic [31:0] hcnt_ff,  nxt_hcnt;
  logic [31:0] ccnt_ff,  nxt_ccnt;
  logic        hseen_ff, nxt_hseen;
  logic        cseen_ff, nxt_cseen;
  logic        nxt_hotf, nxt_coldf;
  logic        host_ff,  nxt_host;
  logic        aseen_ff, nxt_aseen;
  logic        bias_ff;

  always_comb
  begin
    nxt_ts    = ts_ff;
    nxt_tcnt  = tcnt_ff + 32'h1;
    nxt_hcnt  = 32'h0;
    nxt_ccnt  = 32'h0;
    nxt_hseen = hseen_ff;
    nxt_cseen = cseen_ff;
    nxt_hotf  = hotf_ff;
    nxt_coldf = coldf_ff;
    nxt_host  = host_ff;
    nxt_aseen = aseen_ff;
    case (ts_ff)
      TEMP_BIAS_OUTPUT:
      begin
        // after reset the bias flop rises one edge late; hold the count so every window is full
        if (!bias_ff)
          nxt_tcnt = tcnt_ff; // R11
        // a comparator must hold its level for the whole deglitch time
        if (s2_ff[P_HOT])
          nxt_hcnt = cnt_done(hcnt_ff, DGL_CYC) ? hcnt_ff : hcnt_ff + 32'h1; // R11
        if (s2_ff[P_COLD])
          nxt_ccnt = cnt_done(ccnt_ff, DGL_CYC) ? ccnt_ff : ccnt_ff + 32'h1; // R11
        if (cnt_done(hcnt_ff, DGL_CYC) && s2_ff[P_HOT])
          nxt_hseen = 1'b1; // R14
        if (cnt_done(ccnt_ff, DGL_CYC) && s2_ff[P_COLD])
          nxt_cseen = 1'b1; // R14
        if (cnt_done(tcnt_ff, BIAS_CYC))
        begin
          nxt_ts    = TS_MON; // R12
          nxt_tcnt  = 32'h0;
          nxt_hotf  = nxt_hseen; // R11 R14
          nxt_coldf = nxt_cseen; // R11 R14
          nxt_aseen = 1'b0;
        end
      end
      TS_MON:
      begin
        nxt_aseen = aseen_ff | s2_ff[P_HOST]; // R13
        if (cnt_done(tcnt_ff, priority_period ? MON_P_CYC : MON_S_CYC))
        begin
          nxt_ts    = TEMP_BIAS_OUTPUT;
          nxt_tcnt  = 32'h0;
          nxt_host  = nxt_aseen; // R13
          nxt_hseen = 1'b0;
          nxt_cseen = 1'b0;
        end
      end
      default:
      begin
        nxt_ts   = TEMP_BIAS_OUTPUT;
        nxt_tcnt = 32'h0;
      end
    endcase
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      ts_ff    <= TEMP_BIAS_OUTPUT;
      tcnt_ff  <= 32'h0;
      hcnt_ff  <= 32'h0;
      ccnt_ff  <= 32'h0;
      hseen_ff <= 1'b0;
      cseen_ff <= 1'b0;
      hotf_ff  <= 1'b0;
      coldf_ff <= 1'b0;
      host_ff  <= 1'b0;
      aseen_ff <= 1'b0;
    end
    else if (ce)
    begin
      ts_ff    <= nxt_ts;
      tcnt_ff  <= nxt_tcnt;
      hcnt_ff  <= nxt_hcnt;
      ccnt_ff  <= nxt_ccnt;
      hseen_ff <= nxt_hseen;
      cseen_ff <= nxt_cseen;
      hotf_ff  <= nxt_hotf;
      coldf_ff <= nxt_coldf;
      host_ff  <= nxt_host;
      aseen_ff <= nxt_aseen;
    end
  end

  // packet scheduler: header, payload, xor checksum
  wrbc_pk_type pk_ff,    nxt_pk;
  logic [1:0]  idx_ff,   nxt_idx;
  logic [7:0]  hdr_ff,   nxt_hdr;
  logic [7:0]  pay_ff,   nxt_pay;
  logic [31:0] icnt_ff,  nxt_icnt;
  logic        ept_ff,   nxt_ept;
  logic        eptd_ff,  nxt_eptd;

  always_comb
  begin
    nxt_pk   = pk_ff;
    nxt_idx  = idx_ff;
    nxt_hdr  = hdr_ff;
    nxt_pay  = pay_ff;
    nxt_icnt = icnt_ff;
    // overheat event is latched once; set beats the clear when both land
    nxt_ept  = ept_ff;
    nxt_eptd = eptd_ff & s2_ff[P_DIE];
    if (conv_ff && !cnt_done(icnt_ff, CE_INT_CYC))
      nxt_icnt = icnt_ff + 32'h1;
    txi.tx_valid = (pk_ff == PK_SEND);
    case (idx_ff)
      2'h0:    txi.tx_byte = hdr_ff;
      2'h1:    txi.tx_byte = pay_ff;
      default: txi.tx_byte = hdr_ff ^ pay_ff;
    endcase
    case (pk_ff)
      PK_IDLE:
        if (ept_ff)
        begin
          nxt_pk  = PK_SEND;
          nxt_idx = 2'h0;
          nxt_hdr = HDR_EPT; // R15
          nxt_pay = EPT_INT_FAULT; // R15
          nxt_ept = 1'b0;
        end
        else if (conv_ff && cnt_done(icnt_ff, CE_INT_CYC))
        begin
          nxt_pk   = PK_SEND; // R16
          nxt_idx  = 2'h0;
          nxt_hdr  = HDR_CTRL_ERR;
          nxt_pay  = ctrl_err_value;
          nxt_icnt = 32'h0;
        end
      PK_SEND:
        if (txi.tx_ready)
        begin
          nxt_idx = idx_ff + 2'h1;
          if (idx_ff == 2'h2)
            nxt_pk = PK_IDLE;
        end
      default:
        nxt_pk = PK_IDLE;
    endcase
    if (s2_ff[P_DIE] && !eptd_ff)
    begin
      nxt_ept  = 1'b1; // R15
      nxt_eptd = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      pk_ff   <= PK_IDLE;
      idx_ff  <= 2'h0;
      hdr_ff  <= 8'h00;
      pay_ff  <= 8'h00;
      icnt_ff <= 32'h0;
      ept_ff  <= 1'b0;
      eptd_ff <= 1'b0;
    end
    else if (ce)
    begin
      pk_ff   <= nxt_pk;
      idx_ff  <= nxt_idx;
      hdr_ff  <= nxt_hdr;
      pay_ff  <= nxt_pay;
      icnt_ff <= nxt_icnt;
      ept_ff  <= nxt_ept;
      eptd_ff <= nxt_eptd;
    end
  end

  wrbc_biphase_tx #(.HALF_CYC(HALF_CYC)) u_enc (
    .clk  (clk),
    .nrst (nrst),
    .ce   (ce),
    .tx   (txi.snk)
  );

  // output stage: pins straight from flops, except power_good_n_o tied low and the rectifier pins decoded from rm_ff
  logic pgoe_ff;
  logic moda_ff;
  logic modb_ff;

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      pgoe_ff <= 1'b0;
      moda_ff <= 1'b0;
      modb_ff <= 1'b0;
      bias_ff <= 1'b0;
    end
    else if (ce)
    begin
      pgoe_ff <= nxt_sup; // R1
      moda_ff <= txi.mod_on; // R7
      modb_ff <= txi.mod_on; // R7
      bias_ff <= (nxt_ts == TEMP_BIAS_OUTPUT); // R11 R12
    end
  end

  assign power_good_n_o      = 1'b0;
  assign power_good_n_oe     = pgoe_ff;
  assign supply_enable       = sup_ff;
  assign rect_half_sync      = (rm_ff == RM_HALF);
  assign rect_full_sync      = (rm_ff == RM_FULL);
  assign comm_limit_en       = cle_ff;
  assign comm_limit_ma       = clm_ff;
  assign temp_bias_window    = bias_ff;
  assign temp_bias_output_oe = bias_ff;
  assign hot_fault           = hotf_ff;
  assign cold_fault          = coldf_ff;
  assign host_ctrl           = host_ff;
  assign modulation_switch_a = moda_ff;
  assign modulation_switch_b = modb_ff;
endmodule // wrbc_ctrl

//--- hw/wrbc_pkg.sv
// constants and types shared by the receiver control block
package wrbc_pkg;
  localparam int CLK_MHZ          = 100;
  localparam int BIT_PERIOD_US    = 500;
  localparam int HALF_BIT_CYC     = BIT_PERIOD_US * CLK_MHZ / 2;
  localparam int CYC_PER_MS       = CLK_MHZ * 1000;
  localparam int BIAS_WIN_MS      = 24;
  localparam int DEGLITCH_MS      = 10;
  localparam int MON_PRIO_MS      = 35;
  localparam int MON_STD_MS       = 235;
  localparam int CE_INTERVAL_MS   = 250;
  localparam int BIAS_WIN_CYC     = BIAS_WIN_MS * CYC_PER_MS;
  localparam int DEGLITCH_CYC     = DEGLITCH_MS * CYC_PER_MS;
  localparam int MON_PRIO_CYC     = MON_PRIO_MS * CYC_PER_MS;
  localparam int MON_STD_CYC      = MON_STD_MS * CYC_PER_MS;
  localparam int CE_INTERVAL_CYC  = CE_INTERVAL_MS * CYC_PER_MS;
  localparam int FRAME_BITS       = 11;
  localparam int CUR_W            = 12;
  localparam logic [CUR_W-1:0] CL_KNEE_MA   = 12'h12C;
  localparam logic [CUR_W:0]   CL_FIXED_MA  = 13'h0190;
  localparam logic [CUR_W:0]   CL_MARGIN_MA = 13'h0032;
  localparam logic [CUR_W-1:0] FULL_ON_MA   = 12'h078;
  localparam logic [CUR_W-1:0] FULL_OFF_MA  = 12'h064;
  localparam logic [7:0] HDR_EPT          = 8'h02;
  localparam logic [7:0] HDR_CTRL_ERR     = 8'h03;
  localparam logic [7:0] EPT_INT_FAULT    = 8'h02;
  localparam int PIN_N  = 8;
  localparam int P_CONV = 0;
  localparam int P_UVLO = 1;
  localparam int P_HOT  = 2;
  localparam int P_COLD = 3;
  localparam int P_HOST = 4;
  localparam int P_DIE  = 5;
  localparam int P_ENA  = 6;
  localparam int P_ENB  = 7;
  typedef enum logic [2:0] {RM_OFF = 3'b001, RM_HALF = 3'b010, RM_FULL = 3'b100} wrbc_rect_type;
  typedef enum logic [1:0] {TEMP_BIAS_OUTPUT = 2'b01, TS_MON = 2'b10} wrbc_ts_type;
  typedef enum logic [1:0] {PK_IDLE = 2'b01, PK_SEND = 2'b10} wrbc_pk_type;
endpackage

//--- hw/wrbc_tx_if.sv
// byte hand-off and modulation level between packet logic and encoder
`timescale 1ns/1ns
interface wrbc_tx_if;
  logic [7:0] tx_byte;
  logic       tx_valid;
  logic       tx_ready;
  logic       mod_on;
  modport src (output tx_byte, output tx_valid, input tx_ready, input mod_on);
  modport snk (input tx_byte, input tx_valid, output tx_ready, output mod_on);
endinterface

//--- hw/wrbc_biphase_tx.sv
// byte framer and differential biphase encoder
`timescale 1ns/1ns
module wrbc_biphase_tx
  import wrbc_pkg::*;
#(
  parameter int HALF_CYC = HALF_BIT_CYC
)(
  input  wire logic clk,
  input  wire logic nrst,
  input  wire logic ce,
  wrbc_tx_if.snk    tx
);
  logic [31:0] cnt_ff,  nxt_cnt;
  logic [10:0] shf_ff,  nxt_shf;
  logic [3:0]  bit_ff,  nxt_bit;
  logic        half_ff, nxt_half;
  logic        act_ff,  nxt_act;
  logic        lvl_ff,  nxt_lvl;

  always_comb
  begin
    nxt_cnt  = cnt_ff;
    nxt_shf  = shf_ff;
    nxt_bit  = bit_ff;
    nxt_half = half_ff;
    nxt_act  = act_ff;
    nxt_lvl  = lvl_ff;
    tx.tx_ready = !act_ff;
    if (!act_ff)
    begin
      if (tx.tx_valid)
      begin
        // stop, odd parity, data lsb first, start
        nxt_shf  = {1'b1, ~^tx.tx_byte, tx.tx_byte, 1'b0}; // R5 R6
        nxt_bit  = 4'h0;
        nxt_half = 1'b0;
        nxt_cnt  = 32'h0;
        nxt_act  = 1'b1;
        nxt_lvl  = ~lvl_ff; // R4
      end
    end
    else if (cnt_ff == 32'(HALF_CYC - 1)) // R3
    begin
      nxt_cnt = 32'h0;
      if (!half_ff)
      begin
        nxt_half = 1'b1;
        if (shf_ff[0])
          nxt_lvl = ~lvl_ff; // R4
      end
      else
      begin
        nxt_half = 1'b0;
        nxt_shf  = {1'b0, shf_ff[10:1]};
        nxt_bit  = bit_ff + 4'h1;
        if (bit_ff == 4'(FRAME_BITS - 1))
        begin
          // chained byte keeps the phase; otherwise the load is released
          tx.tx_ready = 1'b1;
          if (tx.tx_valid)
          begin
            nxt_shf = {1'b1, ~^tx.tx_byte, tx.tx_byte, 1'b0}; // R5 R6
            nxt_bit = 4'h0;
            nxt_lvl = ~lvl_ff; // R4
          end
          else
          begin
            nxt_act = 1'b0;
            nxt_lvl = 1'b0; // R18
          end
        end
        else
          nxt_lvl = ~lvl_ff; // R4
      end
    end
    else
      nxt_cnt = cnt_ff + 32'h1;
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      cnt_ff  <= 32'h0;
      shf_ff  <= 11'h7FF;
      bit_ff  <= 4'h0;
      half_ff <= 1'b0;
      act_ff  <= 1'b0;
      lvl_ff  <= 1'b0;
    end
    else if (ce)
    begin
      cnt_ff  <= nxt_cnt;
      shf_ff  <= nxt_shf;
      bit_ff  <= nxt_bit;
      half_ff <= nxt_half;
      act_ff  <= nxt_act;
      lvl_ff  <= nxt_lvl;
    end
  end

  assign tx.mod_on = lvl_ff & act_ff; // R18
endmodule // wrbc_biphase_tx

//--- sim/wrbc_ctrl_checker.sv
// port assertions for the receiver control block
`timescale 1ns/1ns
module wrbc_ctrl_checker
  import wrbc_pkg::*;
#(
  parameter int HALF_CYC = HALF_BIT_CYC,
  parameter int BIAS_CYC = BIAS_WIN_CYC
)(
  input wire logic             clk,
  input wire logic             nrst,
  input wire logic             ce,
  input wire logic             rect_above_uvlo,
  input wire logic             enable_select_a,
  input wire logic             enable_select_b,
  input wire logic [CUR_W-1:0] load_current_ma,
  input wire logic             power_good_n_o,
  input wire logic             power_good_n_oe,
  input wire logic             supply_enable,
  input wire logic             rect_half_sync,
  input wire logic             rect_full_sync,
  input wire logic             comm_limit_en,
  input wire logic [CUR_W:0]   comm_limit_ma,
  input wire logic             temp_bias_window,
  input wire logic             temp_bias_output_oe,
  input wire logic             modulation_switch_a,
  input wire logic             modulation_switch_b
);
  logic [31:0]    win_cnt_ff, nxt_win_cnt, hi_cnt_ff, nxt_hi_cnt;
  logic [CUR_W:0] exp_lim;
  always_comb
  begin
    nxt_win_cnt = temp_bias_window ? win_cnt_ff + 32'h1 : 32'h0;
    nxt_hi_cnt  = modulation_switch_a ? hi_cnt_ff + 32'h1 : 32'h0;
    exp_lim = (load_current_ma < CL_KNEE_MA) ? CL_FIXED_MA : {1'b0, load_current_ma} + CL_MARGIN_MA;
  end
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      win_cnt_ff <= 32'h0;
      hi_cnt_ff  <= 32'h0;
    end
    else if (ce)
    begin
      win_cnt_ff <= nxt_win_cnt;
      hi_cnt_ff  <= nxt_hi_cnt;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst || !ce);
  sequence steady_in;
    $stable(rect_above_uvlo) && $stable(load_current_ma);
  endsequence
  // inputs are held a few cycles so the synchroniser delay is covered
  pg_follows_supply_a: assert property (power_good_n_oe == supply_enable && !power_good_n_o)
    else $error("power good pin differs from supply enable");
  switch_pair_a: assert property (modulation_switch_a == modulation_switch_b)
    else $error("modulation switches differ");
  // hold of three after a change fits the shortened half bit of four
  half_bit_hold_a: assert property ($changed(modulation_switch_a) |=> $stable(modulation_switch_a)[*3])
    else $error("switch changed inside a half bit");
  bit_edge_a: assert property (hi_cnt_ff <= 2 * HALF_CYC)
    else $error("switch closed longer than one bit");
  limit_value_a: assert property ($stable(load_current_ma)[*4] |-> comm_limit_ma == exp_lim)
    else $error("communication limit value wrong");
  limit_enable_a: assert property (($stable(enable_select_a) && $stable(enable_select_b))[*5]
    |-> comm_limit_en == !(enable_select_b && !enable_select_a))
    else $error("communication limit enable wrong");
  full_mode_a: assert property (steady_in[*5] ##0 (rect_above_uvlo && load_current_ma > FULL_ON_MA)
    |-> rect_full_sync)
    else $error("full rectification missing");
  half_mode_a: assert property (steady_in[*5] ##0 (rect_above_uvlo && load_current_ma < FULL_OFF_MA)
    |-> rect_half_sync && !rect_full_sync)
    else $error("half rectification missing");
  off_mode_a: assert property (steady_in[*5] ##0 !rect_above_uvlo |-> !rect_half_sync && !rect_full_sync)
    else $error("rectifier not off below lockout");
  bias_len_a: assert property ($fell(temp_bias_window) |-> win_cnt_ff == BIAS_CYC)
    else $error("bias window length wrong");
  bias_hiz_a: assert property (temp_bias_output_oe == temp_bias_window)
    else $error("bias output not released with window");
  cover property ($rose(rect_full_sync));
  cover property ($rose(supply_enable));
  cover property ($rose(modulation_switch_a));
  cover property ($fell(comm_limit_en));
endmodule // wrbc_ctrl_checker
bind wrbc_ctrl wrbc_ctrl_checker #(.HALF_CYC(HALF_CYC), .BIAS_CYC(BIAS_CYC)) u_chk (
  .clk(clk), .nrst(nrst), .ce(ce), .rect_above_uvlo(rect_above_uvlo),
  .enable_select_a(enable_select_a), .enable_select_b(enable_select_b),
  .load_current_ma(load_current_ma), .power_good_n_o(power_good_n_o),
  .power_good_n_oe(power_good_n_oe), .supply_enable(supply_enable),
  .rect_half_sync(rect_half_sync), .rect_full_sync(rect_full_sync),
  .comm_limit_en(comm_limit_en), .comm_limit_ma(comm_limit_ma),
  .temp_bias_window(temp_bias_window), .temp_bias_output_oe(temp_bias_output_oe),
  .modulation_switch_a(modulation_switch_a), .modulation_switch_b(modulation_switch_b));

//--- sim/wrbc_tx_model.sv
// transmitter demodulator: turns the switch level back into byte frames
`timescale 1ns/1ns
module wrbc_tx_model
  import wrbc_pkg::*;
#(
  parameter int HALF_CYC = 4
)(
  input wire logic clk,
  input wire logic sw
);
  logic [10:0] frames[$];
  logic [10:0] fr;
  logic        l1, l2, prev;
  int          edge_err;
  // packet length is fixed at three bytes, as the header would tell a real decoder
  initial
  begin
    edge_err = 0;
    forever
    begin
      @(posedge sw);
      repeat (HALF_CYC / 2) @(posedge clk);
      prev = 1'b0;
      for (int f = 0; f < 3; f++)
      begin
        for (int b = 0; b < FRAME_BITS; b++)
        begin
          l1 = sw;
          repeat (HALF_CYC) @(posedge clk);
          l2 = sw;
          repeat (HALF_CYC) @(posedge clk);
          if (l1 == prev) edge_err++;
          fr[b] = l1 ^ l2;
          prev = l2;
        end
        frames.push_back(fr);
      end
      wait (sw == 1'b0);
    end
  end
endmodule // wrbc_tx_model

//--- sim/wireless_rx_backscatter_ctrl_tb.sv
// self-checking bench for the receiver control block
`timescale 1ns/1ns
module wireless_rx_backscatter_ctrl_tb
  import wrbc_pkg::*;
;
  logic clk, nrst, ce, rect_converged, rect_above_uvlo, hot_threshold, cold_threshold;
  logic host_sense_above, die_shutdown_temp, enable_select_a, enable_select_b, priority_period;
  logic power_good_n_o, power_good_n_oe, supply_enable, rect_half_sync, rect_full_sync;
  logic comm_limit_en, temp_bias_window, temp_bias_output_oe, hot_fault, cold_fault, host_ctrl;
  logic modulation_switch_a, modulation_switch_b;
  logic [CUR_W-1:0] load_current_ma;
  logic [CUR_W:0]   comm_limit_ma;
  logic [7:0]       ctrl_err_value;
  logic [7:0]       exp_q[$];
  int               errors, n_tests, seed, cur, full_m;
  int               cur_tab[4] = '{121, 110, 99, 120};
  // shortened timing so every window and packet fits the run
  localparam int HALF = 4, BIAS = 40, DGL = 10, MONP = 30, MONS = 60, CEINT = 2000;
  wrbc_ctrl #(.HALF_CYC(HALF), .BIAS_CYC(BIAS), .DGL_CYC(DGL), .MON_P_CYC(MONP),
    .MON_S_CYC(MONS), .CE_INT_CYC(CEINT)) uut (
    .clk(clk), .nrst(nrst), .ce(ce), .rect_converged(rect_converged),
    .rect_above_uvlo(rect_above_uvlo), .hot_threshold(hot_threshold),
    .cold_threshold(cold_threshold), .host_sense_above(host_sense_above),
    .die_shutdown_temp(die_shutdown_temp), .enable_select_a(enable_select_a),
    .enable_select_b(enable_select_b), .load_current_ma(load_current_ma),
    .ctrl_err_value(ctrl_err_value), .priority_period(priority_period),
    .power_good_n_o(power_good_n_o), .power_good_n_oe(power_good_n_oe),
    .supply_enable(supply_enable), .rect_half_sync(rect_half_sync),
    .rect_full_sync(rect_full_sync), .comm_limit_en(comm_limit_en),
    .comm_limit_ma(comm_limit_ma), .temp_bias_window(temp_bias_window),
    .temp_bias_output_oe(temp_bias_output_oe), .hot_fault(hot_fault),
    .cold_fault(cold_fault), .host_ctrl(host_ctrl),
    .modulation_switch_a(modulation_switch_a), .modulation_switch_b(modulation_switch_b));
  wrbc_tx_model #(.HALF_CYC(HALF)) tx (.clk(clk), .sw(modulation_switch_a));
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      errors++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // frames are compared against bytes worked out here, with odd parity
  task automatic expect_packet(input logic [7:0] hdr, input logic [7:0] pay);
    exp_q = '{hdr, pay, hdr ^ pay};
    for (int i = 0; i < 3000 && tx.frames.size() < 3; i++) step(1);
    while (exp_q.size() > 0)
    begin
      check(tx.frames.size() > 0 ? tx.frames.pop_front() : 11'h000,
        {1'b1, ~^exp_q[0], exp_q[0], 1'b0});
      void'(exp_q.pop_front());
    end
    check(tx.edge_err, 0);
  endtask
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial
  begin
    repeat (20000) @(posedge clk);
    errors++;
    complete_run();
  end
  initial
  begin
    seed = 91;
    {nrst, rect_converged, rect_above_uvlo, hot_threshold, cold_threshold, host_sense_above,
      die_shutdown_temp, enable_select_a, enable_select_b, priority_period} = '0;
    load_current_ma = 12'h000;
    ce = 1'b1;
    ctrl_err_value = 8'($random(seed));
    step(2);
    check({supply_enable, comm_limit_en, modulation_switch_a, comm_limit_ma}, 16'h4190);
    nrst = 1'b1;
    rect_above_uvlo = 1'b1;
    step(6);
    check({rect_half_sync, rect_full_sync}, 2'b10);
    full_m = 0;
    foreach (cur_tab[i])
    begin
      load_current_ma = 12'(cur_tab[i]);
      step(6);
      if (cur_tab[i] > 120) full_m = 1;
      else if (cur_tab[i] < 100) full_m = 0;
      check({rect_half_sync, rect_full_sync}, {full_m == 0, full_m == 1});
    end
    rect_above_uvlo = 1'b0;
    step(6);
    check({rect_half_sync, rect_full_sync}, 2'b00);
    rect_above_uvlo = 1'b1;
    $display("rectifier test done");
    for (int i = 0; i < 12; i++)
    begin
      cur = (i < 3) ? 299 + i : ($random(seed) & 32'h3FF);
      load_current_ma = 12'(cur);
      step(6);
      check(comm_limit_ma, (cur < 300) ? 400 : cur + 50);
    end
    // clock enable low must freeze the limit; it catches up on the first enabled edge
    ce = 1'b0;
    load_current_ma = 12'h3E8;
    step(6);
    check(comm_limit_ma, (cur < 300) ? 400 : cur + 50);
    ce = 1'b1;
    step(1);
    check(comm_limit_ma, 1000 + 50);
    for (int i = 0; i < 4; i++)
    begin
      {enable_select_a, enable_select_b} = 2'(i);
      step(6);
      check(comm_limit_en, !(enable_select_b && !enable_select_a));
    end
    {enable_select_a, enable_select_b} = 2'b00;
    load_current_ma = 12'h050;
    $display("limit test done");
    step(6);
    check(supply_enable, 1'b0);
    rect_converged = 1'b1;
    step(2);
    check(supply_enable, 1'b0);
    step(4);
    check({supply_enable, power_good_n_oe}, 2'b11);
    $display("supply test done");
    for (int k = 0; k < 3; k++)
    begin
      {cold_threshold, hot_threshold} = (k == 2) ? 2'b01 : 2'(k + 1);
      step(k == 2 ? 5 : 250);
      {cold_threshold, hot_threshold} = 2'b00;
      if (k == 2) step(250);
      check({hot_fault, cold_fault, supply_enable}, k == 2 ? 3'b001 : {k == 0, k == 1, 1'b0});
      step(250);
      check({hot_fault, cold_fault, supply_enable}, 3'b001);
    end
    host_sense_above = 1'b1;
    priority_period = 1'b1;
    step(250);
    check(host_ctrl, 1'b1);
    host_sense_above = 1'b0;
    priority_period = 1'b0;
    step(250);
    check(host_ctrl, 1'b0);
    $display("temperature test done");
    expect_packet(HDR_CTRL_ERR, ctrl_err_value);
    die_shutdown_temp = 1'b1;
    step(6);
    check(supply_enable, 1'b0);
    expect_packet(HDR_EPT, EPT_INT_FAULT);
    $display("packet test done");
    complete_run();
  end
endmodule // wireless_rx_backscatter_ctrl_tb
